// *** dv/exs_prio_model.sv ***
// Purpose: stand-in for the priority logic that grants exception takes
// Assumes: bench asks for a take by index; grant follows one cycle later
// Notes: it grants whatever it is told, so refusal by the unit can be tested
`timescale 1ns/1ns
module exs_prio_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [2:0] idx,
  output logic take_valid,
  output logic [2:0] take_idx
);
  initial begin
    take_valid = 1'b0;
    take_idx = 3'h7;
  end
  // the grant lasts as long as go is held, one cycle per take from the bench; idle shows the none index
  always @(negedge mclk) begin
    take_valid <= go;
    take_idx <= go ? idx : 3'h7;
  end
endmodule

// *** dv/exs_unit_bench.sv ***
// Purpose: self-checking bench for the exception event source unit
// Assumes: inputs change on the falling edge; outputs read one falling edge later
// Notes: each source is raised, taken and returned from in turn
`timescale 1ns/1ns
module exs_unit_bench;
  import exs_pkg::*;
  logic mclk, arst_n, clk_en, go, dpend, tick, ext, exc_return;
  logic [2:0] gidx, take_idx;
  logic take_valid, sync_fault, imprecise_fault, handler_mode, privileged, instr_suppress;
  logic [7:0] pending;
  exs_pipe_ev_t pipe_ev;
  exs_take_t taken;
  int bad_count = 0;
  int checked = 0;
  exs_unit i_dut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .pipe_ev(pipe_ev),
    .deferred_call_set_pending_bit(dpend), .system_tick_timer(tick), .ext_irq_req(ext),
    .take_valid(take_valid), .take_idx(take_idx), .exc_return(exc_return), .pending(pending),
    .sync_fault(sync_fault), .imprecise_fault(imprecise_fault), .taken(taken),
    .handler_mode(handler_mode), .privileged(privileged), .instr_suppress(instr_suppress));
  exs_prio_model i_prio (.mclk(mclk), .go(go), .idx(gidx), .take_valid(take_valid), .take_idx(take_idx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("counts: checked=%0d bad=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pulse(input logic [5:0] e, input logic [2:0] o);
    @(negedge mclk);
    pipe_ev <= e;
    {dpend, tick, ext} <= o;
    @(negedge mclk);
    pipe_ev <= 6'h00;
    {dpend, tick, ext} <= 3'h0;
  endtask
  task automatic take(input logic [2:0] i);
    @(negedge mclk);
    go <= 1'b1;
    gidx <= i;
    @(negedge mclk);
    go <= 1'b0;
    @(negedge mclk);
  endtask
  // raise one source, check its flags, take it, then return to thread mode
  task automatic src(input logic [5:0] e, input logic [2:0] o, input logic [2:0] i, input logic [1:0] c,
                     input logic [2:0] fl);
    pulse(e, o);
    chk(pending, 8'h01 << i);
    chk({5'h00, sync_fault, instr_suppress, imprecise_fault}, {5'h00, fl});
    take(i);
    chk({4'h0, taken.valid, taken.idx}, {4'h0, 1'b1, i});
    if (c !== 2'h0) chk({6'h00, taken.cls}, {6'h00, c});
    chk(pending, 8'h00);
    chk({6'h00, handler_mode, privileged}, 8'h03);
    @(negedge mclk);
    exc_return <= 1'b1;
    @(negedge mclk);
    exc_return <= 1'b0;
    @(negedge mclk);
    chk({6'h00, handler_mode, privileged}, 8'h00);
    $display("test done: source %0d", i);
  endtask
  // a take for nothing pending, then the deferred call raised only by its bit
  task automatic t_deferred;
    take(3'h5);
    chk({7'h00, taken.valid}, 8'h00);
    chk(pending, 8'h00);
    chk({7'h00, handler_mode}, 8'h00);
    src(6'h00, 3'h4, 3'h5, 2'h0, 3'h1);
    $display("test done: deferred");
  endtask
  // a tick held high through its own take stays pending: the set wins over the clear
  task automatic t_retake;
    @(negedge mclk);
    tick <= 1'b1;
    take(3'h4);
    chk(pending, 8'h10);
    chk({7'h00, taken.valid}, 8'h01);
    tick <= 1'b0;
    take(3'h4);
    chk(pending, 8'h00);
    @(negedge mclk);
    exc_return <= 1'b1;
    @(negedge mclk);
    exc_return <= 1'b0;
    @(negedge mclk);
    chk({6'h00, handler_mode, privileged}, 8'h00);
    $display("test done: retake");
  endtask
  // state after the first release, then a second reset in mid-run while in handler mode
  task automatic t_reset;
    chk(pending, 8'h00);
    chk({5'h00, sync_fault, handler_mode, privileged}, 8'h00);
    chk({2'h0, taken}, 8'h1d);
    pulse(6'h20, 3'h2);
    chk(pending, 8'h11);
    take(3'h0);
    chk({6'h00, handler_mode, privileged}, 8'h03);
    @(negedge mclk);
    arst_n = 1'b0;
    @(negedge mclk);
    chk(pending, 8'h00);
    chk({2'h0, taken}, 8'h1d);
    arst_n = 1'b1;
    @(negedge mclk);
    chk({6'h00, handler_mode, privileged}, 8'h00);
    $display("test done: reset");
  endtask
  task automatic t_frozen;
    @(negedge mclk);
    clk_en <= 1'b0;
    pulse(6'h20, 3'h0);
    chk(pending, 8'h00);
    chk({7'h00, sync_fault}, 8'h00);
    clk_en <= 1'b1;
    $display("test done: frozen");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    pipe_ev = 6'h00;
    {dpend, tick, ext, go, exc_return} = 5'h00;
    gidx = 3'h7;
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    t_reset();
    src(6'h20, 3'h0, 3'h0, 2'h1, 3'h4);
    src(6'h10, 3'h0, 3'h1, 2'h1, 3'h6);
    src(6'h08, 3'h0, 3'h2, 2'h1, 3'h4);
    src(6'h02, 3'h0, 3'h3, 2'h0, 3'h0);
    src(6'h01, 3'h0, 3'h3, 2'h0, 3'h0);
    src(6'h00, 3'h2, 3'h4, 2'h3, 3'h0);
    src(6'h00, 3'h1, 3'h6, 2'h3, 3'h0);
    src(6'h04, 3'h0, 3'h2, 2'h2, 3'h1);
    t_deferred();
    t_retake();
    t_frozen();
    stop_test();
  end
endmodule

// *** hdl/exs_pkg.sv ***
// Purpose: shared types and constants for the exception event source unit
// Assumes: one processor clock, no software-visible registers in this block
// Notes: exception numbering is internal to this block
package exs_pkg;
  localparam int EXS_NSRC = 8;
  localparam logic [2:0] EXS_IDX_SUPCALL = 3'h0;
  localparam logic [2:0] EXS_IDX_USAGE = 3'h1;
  localparam logic [2:0] EXS_IDX_DATA = 3'h2;
  localparam logic [2:0] EXS_IDX_DBGMON = 3'h3;
  localparam logic [2:0] EXS_IDX_TICK = 3'h4;
  localparam logic [2:0] EXS_IDX_DEFER = 3'h5;
  localparam logic [2:0] EXS_IDX_EXTIRQ = 3'h6;
  localparam logic [2:0] EXS_IDX_NONE = 3'h7;
  localparam logic [EXS_NSRC-1:0] EXS_PEND_RST = 8'h00;

  typedef enum logic [1:0] {
    EXS_CLS_SYNC = 2'h1,
    EXS_CLS_IMPRECISE = 2'h2,
    EXS_CLS_ASYNC = 2'h3
  } exs_cls_t;

  typedef enum logic [1:0] {
    EXS_ST_THREAD = 2'h1,
    EXS_ST_HANDLER = 2'h2
  } exs_state_t;

  // instruction-related events from the pipeline, one-cycle pulses
  typedef struct packed {
    logic supervisor_call_instruction;
    logic undefined_instr;
    logic data_access_error;
    logic data_error_imprecise;
    logic breakpoint_instruction;
    logic debug_event_ext;
  } exs_pipe_ev_t;

  // report of a taken exception
  typedef struct packed {
    logic valid;
    logic [2:0] idx;
    exs_cls_t cls;
  } exs_take_t;
endpackage

// *** hdl/exs_unit.sv ***
// Purpose: gather system exception sources, classify them and mark them pending
// Assumes: inputs synchronous to mclk; priority logic outside grants one take at a time
// Notes: pending bits are held until the matching exception is taken
`timescale 1ns/1ns
// Function
// RL1: supervisor call instruction raises a supervisor call exception, synchronously
// RL2: undefined instruction raises a usage fault instead of executing
// RL3: data load or store error is reported as a fault exception
// RL4: debug event raises the debug monitor exception
// RL5: faults are normally synchronous to the causing instruction
// RL6: some system errors are reported as imprecise exceptions
// RL7: interrupt requests are always classed asynchronous
// RL8: deferred call becomes pending only by writing its set-pending bit to 1
// RL9: priority logic decides when the deferred call runs; handler only on take
// RL10: breakpoint instruction generates a debug event
// RL11: system tick timer raises its own interrupt exception
// RL12: every handler runs privileged in handler mode
// RL13: taking an exception clears its pending indication
module exs_unit (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire exs_pkg::exs_pipe_ev_t pipe_ev,
  input wire logic deferred_call_set_pending_bit,
  input wire logic system_tick_timer,
  input wire logic ext_irq_req,
  input wire logic take_valid,
  input wire logic [2:0] take_idx,
  input wire logic exc_return,
  output logic [7:0] pending,
  output logic sync_fault,
  output logic imprecise_fault,
  output exs_pkg::exs_take_t taken,
  output logic handler_mode,
  output logic privileged,
  output logic instr_suppress
);
  import exs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [EXS_NSRC-1:0] pend_ff;
  logic [EXS_NSRC-1:0] nxt_pend;
  logic [EXS_NSRC-1:0] set_vec;
  logic [EXS_NSRC-1:0] clr_vec;
  logic dbg_ev;
  logic take_ok;
  logic sync_ff;
  logic impr_ff;
  logic supp_ff;
  exs_take_t taken_ff;
  exs_state_t state_ff;
  exs_cls_t take_cls;

  assign dbg_ev = pipe_ev.breakpoint_instruction | pipe_ev.debug_event_ext; // [RL10]
  assign take_ok = take_valid && (take_idx != EXS_IDX_NONE) && pend_ff[take_idx];

  always_comb begin
    set_vec = '0;
    set_vec[EXS_IDX_SUPCALL] = pipe_ev.supervisor_call_instruction; // [RL1]
    set_vec[EXS_IDX_USAGE] = pipe_ev.undefined_instr; // [RL2]
    set_vec[EXS_IDX_DATA] = pipe_ev.data_access_error | pipe_ev.data_error_imprecise; // [RL3]
    set_vec[EXS_IDX_DBGMON] = dbg_ev; // [RL4]
    set_vec[EXS_IDX_TICK] = system_tick_timer; // [RL11]
    set_vec[EXS_IDX_DEFER] = deferred_call_set_pending_bit; // [RL8]
    set_vec[EXS_IDX_EXTIRQ] = ext_irq_req;
    clr_vec = '0;
    if (take_ok) begin
      clr_vec[take_idx] = 1'b1; // [RL13]
    end
    // a new event in the take cycle survives, so it is not lost
    nxt_pend = (pend_ff & ~clr_vec) | set_vec;
  end

  // class follows the index taken, so a late take still reports the nature of its cause
  always_comb begin
    if (take_idx == EXS_IDX_TICK || take_idx == EXS_IDX_EXTIRQ || take_idx == EXS_IDX_DEFER) begin
      take_cls = EXS_CLS_ASYNC; // [RL7]
    end else if (take_idx == EXS_IDX_DATA && impr_ff) begin
      take_cls = EXS_CLS_IMPRECISE; // [RL6]
    end else begin
      take_cls = EXS_CLS_SYNC; // [RL5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_ff <= EXS_PEND_RST;
    end else if (clk_en) begin
      pend_ff <= nxt_pend; // [RL9]
    end
  end

  // fault classification flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_ff <= 1'b0;
      impr_ff <= 1'b0;
      supp_ff <= 1'b0;
    end else if (clk_en) begin
      sync_ff <= pipe_ev.supervisor_call_instruction | pipe_ev.undefined_instr | pipe_ev.data_access_error; // [RL5]
      supp_ff <= pipe_ev.undefined_instr; // [RL2]
      if (pipe_ev.data_error_imprecise) begin
        impr_ff <= 1'b1; // [RL6]
      end else if (pipe_ev.data_access_error) begin
        impr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      taken_ff <= '{valid: 1'b0, idx: EXS_IDX_NONE, cls: EXS_CLS_SYNC};
    end else if (clk_en) begin
      taken_ff.valid <= take_ok; // [RL9]
      if (take_ok) begin
        taken_ff.idx <= take_idx;
        taken_ff.cls <= take_cls;
      end
    end
  end

  // mode tracking: nesting depth is the pipeline's concern, a return with no take in the same cycle means back to thread
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= EXS_ST_THREAD;
    end else if (clk_en) begin
      case (state_ff)
        EXS_ST_THREAD: begin
          if (take_ok) begin
            state_ff <= EXS_ST_HANDLER; // [RL12]
          end
        end
        EXS_ST_HANDLER: begin
          if (exc_return && !take_ok) begin
            state_ff <= EXS_ST_THREAD;
          end
        end
        default: begin
          state_ff <= EXS_ST_THREAD;
        end
      endcase
    end
  end

  assign pending = pend_ff;
  assign sync_fault = sync_ff;
  assign imprecise_fault = impr_ff;
  assign taken = taken_ff;
  // one-hot state: bit 1 is the handler flop itself, so both outputs come straight from it
  assign handler_mode = state_ff[1];
  assign privileged = state_ff[1]; // [RL12]
  assign instr_suppress = supp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // each source but the deferred call and the imprecise data error must land in its pending bit one edge after it is seen
  a_supcall_pends: assert property (@(posedge mclk) disable iff (!arst_n) // [RL1]
    clk_en && pipe_ev.supervisor_call_instruction |=> pend_ff[EXS_IDX_SUPCALL])
    else $error("supervisor call not pending");
  a_undef_usage: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
    clk_en && pipe_ev.undefined_instr |=> pend_ff[EXS_IDX_USAGE] && instr_suppress)
    else $error("undefined instruction gave no usage fault");
  a_supp_undef: assert property (@(posedge mclk) disable iff (!arst_n) // [RL2]
    clk_en && !pipe_ev.undefined_instr |=> !instr_suppress)
    else $error("instruction suppressed without cause");
  a_data_fault: assert property (@(posedge mclk) disable iff (!arst_n) // [RL3]
    clk_en && pipe_ev.data_access_error |=> pend_ff[EXS_IDX_DATA])
    else $error("data error lost");
  a_brk_debug: assert property (@(posedge mclk) disable iff (!arst_n) // [RL10]
    clk_en && pipe_ev.breakpoint_instruction |=> pend_ff[EXS_IDX_DBGMON])
    else $error("breakpoint gave no debug event");
  a_dbgev_monitor: assert property (@(posedge mclk) disable iff (!arst_n) // [RL4]
    clk_en && pipe_ev.debug_event_ext |=> pend_ff[EXS_IDX_DBGMON])
    else $error("debug event gave no monitor exception");
  a_sync_class: assert property (@(posedge mclk) disable iff (!arst_n) // [RL5]
    clk_en && take_ok && take_idx == EXS_IDX_USAGE |=> taken.cls == EXS_CLS_SYNC)
    else $error("usage fault not synchronous");
  a_impr_class: assert property (@(posedge mclk) disable iff (!arst_n) // [RL6]
    clk_en && pipe_ev.data_error_imprecise ##1 clk_en && take_valid && take_idx == EXS_IDX_DATA
    && !pipe_ev.data_access_error |=> taken.cls == EXS_CLS_IMPRECISE)
    else $error("not imprecise");
  a_impr_not_sync: assert property (@(posedge mclk) disable iff (!arst_n) // [RL6]
    clk_en && pipe_ev.data_error_imprecise && !pipe_ev.supervisor_call_instruction
    && !pipe_ev.undefined_instr && !pipe_ev.data_access_error |=> !sync_fault && imprecise_fault)
    else $error("imprecise error flagged as synchronous");
  a_irq_async: assert property (@(posedge mclk) disable iff (!arst_n) // [RL7]
    clk_en && take_ok && (take_idx == EXS_IDX_EXTIRQ || take_idx == EXS_IDX_TICK)
    |=> taken.cls == EXS_CLS_ASYNC)
    else $error("interrupt not asynchronous");
  a_extirq_pends: assert property (@(posedge mclk) disable iff (!arst_n) // [RL7]
    clk_en && ext_irq_req |=> pend_ff[EXS_IDX_EXTIRQ])
    else $error("external interrupt lost");
  a_defer_only: assert property (@(posedge mclk) disable iff (!arst_n) // [RL8]
    clk_en && !pend_ff[EXS_IDX_DEFER] && !deferred_call_set_pending_bit |=> !pend_ff[EXS_IDX_DEFER])
    else $error("deferred call pended without bit");
  a_take_needs_pend: assert property (@(posedge mclk) disable iff (!arst_n) // [RL9]
    clk_en && take_valid && (take_idx == EXS_IDX_NONE || !pend_ff[take_idx]) |=> !taken.valid)
    else $error("take without pending");
  a_tick_pends: assert property (@(posedge mclk) disable iff (!arst_n) // [RL11]
    clk_en && system_tick_timer |=> pend_ff[EXS_IDX_TICK])
    else $error("tick lost");
  a_handler_priv: assert property (@(posedge mclk) disable iff (!arst_n) // [RL12]
    clk_en && take_ok |=> handler_mode && privileged)
    else $error("handler not privileged");
  a_return_thread: assert property (@(posedge mclk) disable iff (!arst_n) // [RL12]
    clk_en && handler_mode && exc_return && !take_ok |=> !handler_mode && !privileged)
    else $error("return did not leave handler mode");
  a_take_clears: assert property (@(posedge mclk) disable iff (!arst_n) // [RL13]
    clk_en && take_ok && take_idx == EXS_IDX_DEFER && !deferred_call_set_pending_bit
    |=> !pend_ff[EXS_IDX_DEFER])
    else $error("pending not cleared");

  // main scenarios: a take of a supervisor call, a tick, a deferred call and an imprecise fault, and a return to thread mode
  c_supcall_taken: cover property (@(posedge mclk) disable iff (!arst_n)
    pipe_ev.supervisor_call_instruction ##[1:5] taken.valid && taken.idx == EXS_IDX_SUPCALL);
  c_tick_taken: cover property (@(posedge mclk) disable iff (!arst_n)
    taken.valid && taken.idx == EXS_IDX_TICK && taken.cls == EXS_CLS_ASYNC);
  c_defer_taken: cover property (@(posedge mclk) disable iff (!arst_n)
    deferred_call_set_pending_bit ##[1:5] taken.valid && taken.idx == EXS_IDX_DEFER);
  c_impr_taken: cover property (@(posedge mclk) disable iff (!arst_n)
    taken.valid && taken.cls == EXS_CLS_IMPRECISE);
  c_return: cover property (@(posedge mclk) disable iff (!arst_n)
    handler_mode ##1 !handler_mode);
endmodule
